// ===== hdl/pcsr_regs.vh
// Register indices, field positions, reset values for the PHY control block
`ifndef PCSR_REGS_VH
`define PCSR_REGS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PCSR_IDX_STRAP 10'h019
`define PCSR_IDX_DIAG 10'h01E
`define PCSR_IDX_RESET 10'h01F
`define PCSR_IDX_MATCH_CTL 10'h040
`define PCSR_IDX_MATCH 10'h041
`define PCSR_IDX_LINK 10'h133
`define PCSR_IDX_IRQ_STAT 10'h200
`define PCSR_IDX_IRQ_MASK 10'h201

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PCSR_STRAP_ENERGY 10
`define PCSR_STRAP_FIXED 11
`define PCSR_DIAG_START 15
`define PCSR_DIAG_AUTO 14
`define PCSR_DIAG_DONE 1
`define PCSR_DIAG_FAIL 0
`define PCSR_RST_GLOBAL 15
`define PCSR_RST_RESTART 14
`define PCSR_RST_STANDBY 7
`define PCSR_MCTL_EN 0
`define PCSR_LINK_CS 14
`define PCSR_LINK_SENDING 13
`define PCSR_LINK_UP 12
`define PCSR_LINK_DESCR 2
`define PCSR_LINK_LOC 1
`define PCSR_LINK_REM 0
`define PCSR_IRQ_DIAG_DONE 0
`define PCSR_IRQ_LINK_DOWN 1
`define PCSR_IRQ_MATCH 2

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define PCSR_STRAP_RESET 16'h0800
`define PCSR_MATCH_RESET 16'h88F7
`define PCSR_RST_RW_MASK 16'h3FDF
`define PCSR_IRQ_BITS 3
`define PCSR_STRAP_SETTLE 2'h3
`define PCSR_RESP_OKAY 2'h0
`define PCSR_RESP_SLVERR 2'h2

`endif

// ===== hdl/pcsr_phy_ctrl.v
// PHY control and status register bank with AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "pcsr_regs.vh"

module pcsr_phy_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire energy_detect,
  input wire [4:0] strap_station_id,
  input wire link_up,
  input wire link_up_cs,
  input wire phy_ctrl_sending,
  input wire descr_locked,
  input wire loc_rcvr_ok,
  input wire rem_rcvr_ok,
  output reg tdr_launch,
  input wire tdr_complete,
  input wire tdr_failed,
  input wire rx_type_valid,
  input wire [15:0] rx_type,
  output reg type_match,
  output wire standby_mode,
  output wire digital_restart,
  output wire global_reset,
  output wire irq
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  localparam NSYNC = 12;
  wire [NSYNC-1:0] pin_raw;
  reg [NSYNC-1:0] sync_a;
  reg [NSYNC-1:0] sync_b;
  assign pin_raw = {strap_station_id, energy_detect, link_up, link_up_cs,
                    phy_ctrl_sending, descr_locked, loc_rcvr_ok, rem_rcvr_ok};

  // Two flops per pin; only sync_b is read by logic
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge aclk) begin
        if (!aresetn) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  wire [4:0] strap_s;
  wire energy_s;
  wire link_s;
  wire link_cs_s;
  wire sending_s;
  wire descr_s;
  wire loc_s;
  wire rem_s;
  assign strap_s = sync_b[11:7];
  assign energy_s = sync_b[6];
  assign link_s = sync_b[5];
  assign link_cs_s = sync_b[4];
  assign sending_s = sync_b[3];
  assign descr_s = sync_b[2];
  assign loc_s = sync_b[1];
  assign rem_s = sync_b[0];

  // --------------------------------------------------------------------
  // Register selection
  // --------------------------------------------------------------------
  localparam SEL_NONE = 3'h0;
  localparam SEL_STRAP = 3'h1;
  localparam SEL_DIAG = 3'h2;
  localparam SEL_RESET = 3'h3;
  localparam SEL_MCTL = 3'h4;
  localparam SEL_MATCH = 3'h5;
  localparam SEL_LINK = 3'h6;
  localparam SEL_ISTAT = 3'h7;
  // Mask has no spare code, so it is decoded on its own
  function [3:0] reg_sel;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'h0) begin
        reg_sel = {1'b0, SEL_NONE};
      end else begin
        case (addr[11:2])
          `PCSR_IDX_STRAP: reg_sel = {1'b0, SEL_STRAP};
          `PCSR_IDX_DIAG: reg_sel = {1'b0, SEL_DIAG};
          `PCSR_IDX_RESET: reg_sel = {1'b0, SEL_RESET};
          `PCSR_IDX_MATCH_CTL: reg_sel = {1'b0, SEL_MCTL};
          `PCSR_IDX_MATCH: reg_sel = {1'b0, SEL_MATCH};
          `PCSR_IDX_LINK: reg_sel = {1'b0, SEL_LINK};
          `PCSR_IDX_IRQ_STAT: reg_sel = {1'b0, SEL_ISTAT};
          `PCSR_IDX_IRQ_MASK: reg_sel = {1'b1, SEL_NONE};
          default: reg_sel = {1'b0, SEL_NONE};
        endcase
      end
    end
  endfunction

  // Byte-lane merge of a 16-bit register
  function [15:0] lane_merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      lane_merge[7:0] = strb[0] ? data[7:0] : old[7:0];
      lane_merge[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  // --------------------------------------------------------------------
  // AXI4-Lite write path: address and data taken in either order
  // --------------------------------------------------------------------
  reg aw_held;
  reg w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_fire;
  wire [3:0] wsel;
  wire [15:0] wval;
  wire [15:0] wd16;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wsel = reg_sel(aw_addr);
  assign wd16 = w_data[15:0] & {{8{w_strb[1]}}, {8{w_strb[0]}}};

  // Holding registers and write response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCSR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel == {1'b0, SEL_NONE}) ?
                       `PCSR_RESP_SLVERR : `PCSR_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Software resets
  // --------------------------------------------------------------------
  reg glob_rst;
  reg restart;
  wire reg_rst;
  // Bus handshake survives the global reset so the write still answers
  assign reg_rst = !aresetn || glob_rst;
  assign global_reset = glob_rst;
  assign digital_restart = restart;

  // Self-clearing one-cycle reset bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      glob_rst <= 1'b0;
      restart <= 1'b0;
    end else begin
      glob_rst <= wr_fire && wsel == {1'b0, SEL_RESET} && w_strb[1]
                  && w_data[`PCSR_RST_GLOBAL];
      restart <= wr_fire && wsel == {1'b0, SEL_RESET} && w_strb[1]
                 && w_data[`PCSR_RST_RESTART] && !glob_rst;
    end
  end

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  reg [4:0] strap_id;
  reg [1:0] strap_wait;
  reg [15:0] rst_ctl;
  reg match_en;
  reg [15:0] match_pat;
  reg [`PCSR_IRQ_BITS-1:0] irq_mask;
  reg [`PCSR_IRQ_BITS-1:0] irq_stat;
  reg tdr_start;
  reg tdr_auto;
  reg tdr_busy;
  reg tdr_done;
  reg tdr_fail;
  reg link_prev;
  wire link_down;
  wire start_req;
  wire [`PCSR_IRQ_BITS-1:0] irq_set;
  wire [`PCSR_IRQ_BITS-1:0] irq_clr;
  assign wval = lane_merge(rst_ctl, w_data, w_strb);
  assign link_down = link_prev && !link_s;
  assign start_req = (wr_fire && wsel == {1'b0, SEL_DIAG} && w_strb[1]
                      && w_data[`PCSR_DIAG_START])
                     || (tdr_auto && link_down);

  // Straps are caught once the synchroniser has settled after reset
  always @(posedge aclk) begin
    if (reg_rst) begin
      strap_id <= 5'h00;
      strap_wait <= 2'h0;
    end else if (strap_wait != `PCSR_STRAP_SETTLE) begin
      strap_wait <= strap_wait + 2'h1;
      strap_id <= strap_s;
    end
  end

  // Control registers; reserved read-write bits keep their storage
  always @(posedge aclk) begin
    if (reg_rst) begin
      rst_ctl <= 16'h0000;
      match_en <= 1'b0;
      match_pat <= `PCSR_MATCH_RESET;
      irq_mask <= {`PCSR_IRQ_BITS{1'b0}};
      tdr_auto <= 1'b0;
    end else if (wr_fire) begin
      case (wsel)
        {1'b0, SEL_RESET}: rst_ctl <= wval & `PCSR_RST_RW_MASK;
        {1'b0, SEL_MCTL}: if (w_strb[0]) match_en <= w_data[`PCSR_MCTL_EN];
        {1'b0, SEL_MATCH}: match_pat <= lane_merge(match_pat, w_data, w_strb);
        {1'b1, SEL_NONE}: irq_mask <= wd16[`PCSR_IRQ_BITS-1:0];
        {1'b0, SEL_DIAG}: if (w_strb[1]) tdr_auto <= w_data[`PCSR_DIAG_AUTO];
        default: ;
      endcase
    end
  end
  assign standby_mode = rst_ctl[`PCSR_RST_STANDBY];

  // --------------------------------------------------------------------
  // Reflectometry launch and completion
  // --------------------------------------------------------------------
  // Restart abandons a running measurement but keeps the registers
  always @(posedge aclk) begin
    if (reg_rst) begin
      tdr_start <= 1'b0;
      tdr_busy <= 1'b0;
      tdr_done <= 1'b0;
      tdr_fail <= 1'b0;
      tdr_launch <= 1'b0;
      link_prev <= 1'b0;
    end else begin
      link_prev <= link_s;
      tdr_launch <= 1'b0;
      if (restart) begin
        tdr_start <= 1'b0;
        tdr_busy <= 1'b0;
      end else if (tdr_busy && tdr_complete) begin
        tdr_busy <= 1'b0;
        tdr_start <= 1'b0;
        tdr_done <= 1'b1;
        tdr_fail <= tdr_failed;
      end else if (start_req && !tdr_busy) begin
        tdr_start <= 1'b1;
        tdr_busy <= 1'b1;
        tdr_launch <= 1'b1;
        tdr_done <= 1'b0;
        tdr_fail <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Frame type match
  // --------------------------------------------------------------------
  always @(posedge aclk) begin
    if (reg_rst) begin
      type_match <= 1'b0;
    end else begin
      type_match <= match_en && rx_type_valid && rx_type == match_pat;
    end
  end

  // --------------------------------------------------------------------
  // Interrupts: set wins over a write-one clear
  // --------------------------------------------------------------------
  assign irq_set = {type_match, link_down, tdr_busy && tdr_complete};
  assign irq_clr = (wr_fire && wsel == {1'b0, SEL_ISTAT}) ?
                   wd16[`PCSR_IRQ_BITS-1:0] : {`PCSR_IRQ_BITS{1'b0}};
  always @(posedge aclk) begin
    if (reg_rst) begin
      irq_stat <= {`PCSR_IRQ_BITS{1'b0}};
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // --------------------------------------------------------------------
  // Read data assembly
  // --------------------------------------------------------------------
  reg [15:0] rd_val;
  wire [3:0] rsel;
  assign rsel = reg_sel(s_axi_araddr);

  // Read-only fields come straight from state; reserved bits read zero, except the stored read-write ones of the reset register
  always @* begin
    rd_val = 16'h0000;
    case (rsel)
      {1'b0, SEL_STRAP}: begin
        rd_val = `PCSR_STRAP_RESET;
        rd_val[`PCSR_STRAP_ENERGY] = energy_s;
        rd_val[4:0] = strap_id;
      end
      {1'b0, SEL_DIAG}: begin
        rd_val[`PCSR_DIAG_START] = tdr_start;
        rd_val[`PCSR_DIAG_AUTO] = tdr_auto;
        rd_val[`PCSR_DIAG_DONE] = tdr_done;
        rd_val[`PCSR_DIAG_FAIL] = tdr_fail;
      end
      {1'b0, SEL_RESET}: begin
        rd_val = rst_ctl;
        rd_val[`PCSR_RST_GLOBAL] = glob_rst;
        rd_val[`PCSR_RST_RESTART] = restart;
      end
      {1'b0, SEL_MCTL}: rd_val[`PCSR_MCTL_EN] = match_en;
      {1'b0, SEL_MATCH}: rd_val = match_pat;
      {1'b0, SEL_LINK}: begin
        rd_val[`PCSR_LINK_CS] = link_cs_s;
        rd_val[`PCSR_LINK_SENDING] = sending_s;
        rd_val[`PCSR_LINK_UP] = link_s;
        rd_val[`PCSR_LINK_DESCR] = descr_s;
        rd_val[`PCSR_LINK_LOC] = loc_s;
        rd_val[`PCSR_LINK_REM] = rem_s;
      end
      {1'b0, SEL_ISTAT}: rd_val[`PCSR_IRQ_BITS-1:0] = irq_stat;
      {1'b1, SEL_NONE}: rd_val[`PCSR_IRQ_BITS-1:0] = irq_mask;
      default: rd_val = 16'h0000;
    endcase
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read path: one read under way at a time
  // --------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PCSR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_val};
      s_axi_rresp <= (rsel == {1'b0, SEL_NONE}) ?
                     `PCSR_RESP_SLVERR : `PCSR_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== verif/pcsr_phy_ctrl_properties.sv
// Port-level assertions for the PHY control register block
`timescale 1ns/1ps
`default_nettype none
module pcsr_phy_ctrl_properties (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire tdr_launch,
  input wire rx_type_valid,
  input wire type_match,
  input wire digital_restart
);
  // ----------------------------------------
  // Checks, all in the single clock domain
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Both write channels taken on the same edge
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_write_answer:
    assert property (s_wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two edges after taking");
  a_write_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed early");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one edge after taking");
  a_read_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed early");
  a_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_launch_pulse:
    assert property (tdr_launch |=> !tdr_launch)
    else $error("launch longer than one cycle");
  a_match_cause:
    assert property (type_match |-> $past(rx_type_valid))
    else $error("match pulse without a received type");
  a_restart_pulse:
    assert property (digital_restart |=> !digital_restart)
    else $error("restart longer than one cycle");
endmodule
`default_nettype wire

// ===== verif/pcsr_far_end.sv
// Far-end model: line status pins and the reflectometry engine
`timescale 1ns/1ps
`default_nettype none
module pcsr_far_end (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tdr_launch,
  input wire logic [5:0] line_state,
  input wire logic fail_next,
  input wire logic [7:0] delay,
  output logic [5:0] link_pins,
  output logic tdr_complete,
  output logic tdr_failed,
  output int launches
);
  // --------------------------------
  // Measurement engine
  // --------------------------------
  logic [7:0] left;
  assign link_pins = line_state;
  // Answers each launch after delay cycles; the fail level is only valid
  // beside the done pulse, so it shows the inverse at other times
  always @(posedge aclk) begin
    tdr_complete <= 1'h0;
    tdr_failed <= ~fail_next;
    if (!aresetn) begin
      left <= 8'h00;
      launches <= 0;
    end else if (tdr_launch) begin
      left <= delay;
      launches <= launches + 1;
    end else if (left == 8'h01) begin
      left <= 8'h00;
      tdr_complete <= 1'h1;
      tdr_failed <= fail_next;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the PHY control register block
`timescale 1ns/1ps
`default_nettype none
`include "pcsr_regs.vh"
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_arready, s_axi_rvalid, energy_detect, tdr_launch, tdr_complete;
  logic tdr_failed, rx_type_valid, type_match, standby_mode, digital_restart;
  logic global_reset, irq, fail_next, q_awr, q_wr, q_bv, q_arr, q_rv, q_irq;
  logic q_stby;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, q_bresp, q_rresp, rs;
  logic [15:0] rx_type, q_rdata, rd;
  logic [5:0] line_state, link_pins;
  logic [7:0] delay;
  logic [4:0] strap_station_id;
  wire link_up, link_up_cs, phy_ctrl_sending, descr_locked, loc_rcvr_ok;
  wire rem_rcvr_ok;
  int err_count, samples_checked, cycles, launches, restarts, globals;
  int ready_hold;
  assign {link_up_cs, phy_ctrl_sending, link_up, descr_locked, loc_rcvr_ok,
    rem_rcvr_ok} = link_pins;
  pcsr_phy_ctrl pcsr_phy_ctrl_i (.*);
  pcsr_far_end pcsr_far_end_i (.*);
  // ----------------------------------------
  // Clock, sampling and watchdog
  // ----------------------------------------
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  // Outputs seen mid-cycle equal what the next rising edge samples,
  // which keeps the bus tasks free of scheduling races
  always @(negedge aclk) begin
    q_awr = s_axi_awready;
    q_wr = s_axi_wready;
    q_bv = s_axi_bvalid;
    q_bresp = s_axi_bresp;
    q_arr = s_axi_arready;
    q_rv = s_axi_rvalid;
    q_rdata = s_axi_rdata[15:0];
    q_rresp = s_axi_rresp;
    q_irq = irq;
    q_stby = standby_mode;
  end
  // Pulse counters and hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (digital_restart) restarts <= restarts + 1;
    if (global_reset) globals <= globals + 1;
    if (cycles == 5000) begin
      err_count++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Bus tasks are entered just after a rising edge
  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= (ready_hold == 0);
    do begin
      @(posedge aclk);
      if (q_awr) s_axi_awvalid <= 1'h0;
      if (q_wr) s_axi_wvalid <= 1'h0;
    end while (!q_bv);
    // A slow master lets the answer wait; it must stand meanwhile
    if (ready_hold != 0) begin
      repeat (ready_hold) @(posedge aclk);
      s_axi_bready <= 1'h1;
      @(posedge aclk);
    end
    s_axi_bready <= 1'h0;
    rs = q_bresp;
    @(posedge aclk);
  endtask
  task automatic rd_raw(input logic [9:0] idx);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= (ready_hold == 0);
    do begin
      @(posedge aclk);
      if (q_arr) s_axi_arvalid <= 1'h0;
    end while (!q_rv);
    if (ready_hold != 0) begin
      repeat (ready_hold) @(posedge aclk);
      s_axi_rready <= 1'h1;
      @(posedge aclk);
    end
    s_axi_rready <= 1'h0;
    rd = q_rdata;
    rs = q_rresp;
    @(posedge aclk);
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [15:0] e);
    rd_raw(idx);
    chk(rd, e);
  endtask
  // Reads the diagnostic word until done shows, then judges all of it;
  // a measurement that never ends is judged on its last read
  task automatic poll(input logic [15:0] e);
    for (int n = 0; n < 60; n++) begin
      rd_raw(`PCSR_IDX_DIAG);
      if (rd[1] === 1'h1) break;
    end
    chk(rd, e);
  endtask
  task automatic send(input logic [15:0] t, input logic e);
    rx_type_valid <= 1'h1;
    rx_type <= t;
    @(posedge aclk);
    rx_type_valid <= 1'h0;
    @(negedge aclk);
    chk({15'h0000, type_match}, {15'h0000, e});
    @(posedge aclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_vals;
    rd_chk(`PCSR_IDX_STRAP, 16'h0C15);
    rd_chk(`PCSR_IDX_DIAG, 16'h0000);
    rd_chk(`PCSR_IDX_MATCH, 16'h88F7);
    rd_chk(`PCSR_IDX_LINK, 16'h0000);
    energy_detect <= 1'h0;
    repeat (4) @(posedge aclk);
    rd_chk(`PCSR_IDX_STRAP, 16'h0815);
    wr(`PCSR_IDX_STRAP, 16'hFFFF);
    chk({14'h0000, rs}, 16'h0000);
    rd_chk(`PCSR_IDX_STRAP, 16'h0815);
    wr(`PCSR_IDX_RESET, 16'h3FFF);
    rd_chk(`PCSR_IDX_RESET, 16'h3FDF);
    wr(`PCSR_IDX_RESET, 16'h0000);
    wr(10'h3FF, 16'h1234);
    chk({14'h0000, rs}, 16'h0002);
    rd_chk(10'h3FF, 16'h0000);
    chk({14'h0000, rs}, 16'h0002);
  endtask
  task automatic t_link;
    logic [5:0] v;
    for (int i = 0; i < 7; i++) begin
      v = (i == 6) ? 6'h3F : 6'h01 << i;
      line_state <= v;
      repeat (4) @(posedge aclk);
      rd_chk(`PCSR_IDX_LINK, {1'h0, v[5:3], 9'h000, v[2:0]});
    end
    line_state <= 6'h00;
  endtask
  task automatic t_diag;
    wr(`PCSR_IDX_IRQ_STAT, 16'h0007);
    fail_next <= 1'h1;
    wr(`PCSR_IDX_DIAG, 16'h8000);
    rd_chk(`PCSR_IDX_DIAG, 16'h8000);
    poll(16'h0003);
    chk({15'h0000, q_irq}, 16'h0000);
    wr(`PCSR_IDX_IRQ_MASK, 16'h0001);
    @(posedge aclk);
    chk({15'h0000, q_irq}, 16'h0001);
    wr(`PCSR_IDX_IRQ_STAT, 16'h0001);
    @(posedge aclk);
    chk({15'h0000, q_irq}, 16'h0000);
    fail_next <= 1'h0;
    delay <= 8'h01;
    wr(`PCSR_IDX_DIAG, 16'h8000);
    poll(16'h0002);
  endtask
  task automatic t_auto;
    wr(`PCSR_IDX_IRQ_STAT, 16'h0007);
    wr(`PCSR_IDX_DIAG, 16'h4000);
    line_state <= 6'h08;
    repeat (6) @(posedge aclk);
    line_state <= 6'h00;
    repeat (8) @(posedge aclk);
    poll(16'h4002);
    chk(launches[15:0], 16'h0003);
    rd_chk(`PCSR_IDX_IRQ_STAT, 16'h0003);
    wr(`PCSR_IDX_DIAG, 16'h0000);
    line_state <= 6'h08;
    repeat (6) @(posedge aclk);
    line_state <= 6'h00;
    repeat (10) @(posedge aclk);
    chk(launches[15:0], 16'h0003);
    rd_chk(`PCSR_IDX_DIAG, 16'h0002);
  endtask
  task automatic t_match;
    wr(`PCSR_IDX_MATCH, 16'h1234);
    send(16'h1234, 1'h0);
    wr(`PCSR_IDX_MATCH_CTL, 16'h0001);
    send(16'h1235, 1'h0);
    send(16'h1234, 1'h1);
    rd_chk(`PCSR_IDX_IRQ_STAT, 16'h0007);
  endtask
  task automatic t_rst_ctl;
    wr(`PCSR_IDX_RESET, 16'h0080);
    @(posedge aclk);
    chk({15'h0000, q_stby}, 16'h0001);
    wr(`PCSR_IDX_RESET, 16'h4080);
    rd_chk(`PCSR_IDX_RESET, 16'h0080);
    rd_chk(`PCSR_IDX_MATCH, 16'h1234);
    chk(restarts[15:0], 16'h0001);
    wr(`PCSR_IDX_RESET, 16'h8000);
    repeat (3) @(posedge aclk);
    chk(globals[15:0], 16'h0001);
    rd_chk(`PCSR_IDX_MATCH, 16'h88F7);
    rd_chk(`PCSR_IDX_RESET, 16'h0000);
    chk({15'h0000, q_stby}, 16'h0000);
  endtask
  // Answers held back by a slow master, then a single-lane write
  task automatic t_stall;
    ready_hold = 3;
    wr(`PCSR_IDX_MATCH, 16'h5A5A);
    chk({14'h0000, rs}, 16'h0000);
    rd_chk(`PCSR_IDX_MATCH, 16'h5A5A);
    ready_hold = 0;
    s_axi_wstrb <= 4'h1;
    wr(`PCSR_IDX_MATCH, 16'hFFFF);
    s_axi_wstrb <= 4'hF;
    rd_chk(`PCSR_IDX_MATCH, 16'h5AFF);
  endtask
  initial begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    s_axi_rready = 1'h0;
    {s_axi_awaddr, s_axi_araddr} = 24'h000000;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    energy_detect = 1'h1;
    strap_station_id = 5'h15;
    {rx_type_valid, fail_next} = 2'h0;
    rx_type = 16'h0000;
    line_state = 6'h00;
    delay = 8'h1E;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    t_reset_vals;
    t_link;
    t_diag;
    t_auto;
    t_match;
    t_rst_ctl;
    t_stall;
    tally_and_finish;
  end
endmodule
bind pcsr_phy_ctrl pcsr_phy_ctrl_properties pcsr_phy_ctrl_properties_i (.*);
`default_nettype wire
